/* hw/fdcreg_pkg.sv */
// Purpose: Constants for the floppy status, output and tape register group.
// Assumes: Wishbone byte addresses are four times the register index.
// Notes: Mode codes select legacy, full-status and latched-status views.
package fdcreg_pkg;
   localparam logic [11:0] IDX_STATUS_B = 12'h03f1;
   localparam logic [11:0] IDX_DRIVE_OUT = 12'h03f2;
   localparam logic [11:0] IDX_TAPE = 12'h03f3;
   localparam logic [11:0] IDX_MODE = 12'h0400;
   localparam logic [11:0] IDX_DIR_READ = 12'h0401;
   localparam int ADDR_W = 14;
   localparam logic [1:0] MODE_LEGACY = 2'h0;
   localparam logic [1:0] MODE_FULL = 2'h1;
   localparam logic [1:0] MODE_LATCHED = 2'h2;
   localparam logic [7:0] DRIVE_OUT_RESET = 8'h00;
   localparam logic [7:0] CFG_BYTE_RESET = 8'h00;
   localparam int BIT_SOFT_RESET_N = 2;
   localparam int BIT_DMA_EN = 3;
   localparam int BIT_MOTOR0 = 4;
   localparam int BIT_MOTOR1 = 5;
   localparam int SOFT_RESET_MIN_NS = 100;
   localparam int CLK_PERIOD_NS = 25;
   localparam int SOFT_RESET_CYCLES =
      (SOFT_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* hw/fdcreg_top.sv */
// Purpose: Status B, drive output and tape registers of a floppy controller.
// Assumes: Classic Wishbone slave, 8-bit data in the low lane of 32 bits.
// Notes: Mapped reads answer with ack one cycle after the request is seen.
// Functional notes
// (RQ1) Legacy mode status B read leaves bus undriven
// (RQ2) Full mode status B bits 7,6 read one
// (RQ3) Full mode bits 1:0 show motor enables; bit 1 reads constant zero here
// (RQ4) Full mode bit 2 shows write gate
// (RQ5) Full mode bit 3 toggles on read data
// (RQ6) Full mode bit 4 toggles on write data
// (RQ7) Full mode bit 5 mirrors drive select bit
// (RQ8) Latched bit 2 sets on write gate rise
// (RQ9) Latched bit 3 sets on read data end
// (RQ10) Latched bit 4 sets on write data end
// (RQ11) Latched bit 5 drive select low; others one
// (RQ12) Output register hardware reset only, writable always
// (RQ13) Bits 1:0 binary drive number, one select
// (RQ14) Bit 2 low holds controller in reset
// (RQ15) Reset bit held low at least 100ns
// (RQ16) Legacy/latched: bit 3 gates DMA and interrupt
// (RQ17) Full mode: DMA and interrupt always enabled
// (RQ18) Bits 4,5 drive active-low motor pins
// (RQ19) Normal decode selects drive per bits
// (RQ20) Swapped decode exchanges selects and motors
// (RQ21) Tape field names drive 1..3 or none
// (RQ22) Normal tape read: bits 7:2 zero
// (RQ23) Enhanced tape read: 3:2 zero, 5:4 type
// (RQ24) Type bits picked from config byte pair
// (RQ25) Unsupported pins constant; swap from input
module fdcreg_top #(
   parameter int SOFT_RESET_HOLD = fdcreg_pkg::SOFT_RESET_CYCLES
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [fdcreg_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   output logic dataBusOe,
   input wire logic readDataIn,
   input wire logic writeGateIn,
   input wire logic writeDataIn,
   input wire logic swapDrives,
   input wire logic [7:0] driveTypeCfg,
   input wire logic dmaReqIn,
   input wire logic irqIn,
   output logic driveSelect0N,
   output logic driveSelect1N,
   output logic motorOn0N,
   output logic motorOn1N,
   output logic dmaReqOut,
   output logic irqOut,
   output logic controllerResetN
);
   logic [2:0] rdSync;
   logic [2:0] wgSync;
   logic [2:0] wdSync;
   logic [7:0] driveOutputReg;
   logic [1:0] tapeDriveReg;
   logic [1:0] statusMode;
   logic enhancedTape;
   logic readToggle;
   logic writeToggle;
   logic wgLatch;
   logic rdLatch;
   logic wdLatch;
   logic [3:0] resetHoldCnt;
   logic [11:0] regIdx;
   logic request;
   logic writeHit;
   logic readHit;
   logic dirRead;
   logic rdFall;
   logic wdFall;
   logic wgRise;
   logic lowSel;
   logic [7:0] statusFull;
   logic [7:0] statusLatched;
   logic [7:0] tapeRead;
   logic [7:0] next_readData;
   logic mapped;
   logic driveEn0;
   logic driveEn1;
   logic dmaIrqEnable;

   assign regIdx = wb_adr_i[fdcreg_pkg::ADDR_W-1:2];
   assign request = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign lowSel = wb_sel_i[0];
   assign writeHit = request && wb_we_i && lowSel;
   assign readHit = request && !wb_we_i;
   assign dirRead = readHit && regIdx == fdcreg_pkg::IDX_DIR_READ;

   // Pin inputs pass three flops; only the second and third stages are read.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdSync <= 3'h0;
         wgSync <= 3'h0;
         wdSync <= 3'h0;
      end else begin
         rdSync <= {rdSync[1:0], readDataIn};
         wgSync <= {wgSync[1:0], writeGateIn};
         wdSync <= {wdSync[1:0], writeDataIn};
      end
   end

   // Pins are active high here, so the inactive edge is a fall.
   assign rdFall = rdSync[2] && !rdSync[1];
   assign wdFall = wdSync[2] && !wdSync[1];
   assign wgRise = !wgSync[2] && wgSync[1];

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mapped <= 1'b0;
      end else begin
         mapped <= 1'b0;
         if (request) begin
            case (regIdx)
               fdcreg_pkg::IDX_STATUS_B,
               fdcreg_pkg::IDX_DRIVE_OUT,
               fdcreg_pkg::IDX_TAPE,
               fdcreg_pkg::IDX_MODE,
               fdcreg_pkg::IDX_DIR_READ: mapped <= 1'b1;
               default: mapped <= 1'b0;
            endcase
         end
      end
   end

   // Only a hardware reset clears this register. (see RQ12)
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         driveOutputReg <= fdcreg_pkg::DRIVE_OUT_RESET;
      end else if (writeHit && regIdx == fdcreg_pkg::IDX_DRIVE_OUT) begin
         driveOutputReg <= wb_dat_i[7:0]; // see RQ12
      end
   end

   // Tape field is untouched by software reset; drive 0 has no code. (see RQ21)
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tapeDriveReg <= 2'h0;
      end else if (writeHit && regIdx == fdcreg_pkg::IDX_TAPE) begin
         tapeDriveReg <= wb_dat_i[1:0]; // see RQ21
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         statusMode <= fdcreg_pkg::MODE_LEGACY;
         enhancedTape <= 1'b0;
      end else if (writeHit && regIdx == fdcreg_pkg::IDX_MODE) begin
         statusMode <= wb_dat_i[1:0];
         enhancedTape <= wb_dat_i[4];
      end
   end

   // Software reset holds for a minimum count even after a quick rewrite.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         resetHoldCnt <= 4'h0;
         controllerResetN <= 1'b0;
      end else begin
         if (!driveOutputReg[fdcreg_pkg::BIT_SOFT_RESET_N]) begin
            resetHoldCnt <= 4'(SOFT_RESET_HOLD); // see RQ15
         end else if (resetHoldCnt != 4'h0) begin
            resetHoldCnt <= resetHoldCnt - 4'h1;
         end
         controllerResetN <= driveOutputReg[fdcreg_pkg::BIT_SOFT_RESET_N]
            && resetHoldCnt == 4'h0; // see RQ14
      end
   end

   // Toggles clear only with hardware reset; latches clear with hardware reset or a DIR read.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         readToggle <= 1'b0;
         writeToggle <= 1'b0;
      end else begin
         if (rdFall) begin
            readToggle <= !readToggle; // see RQ5
         end
         if (wdFall) begin
            writeToggle <= !writeToggle; // see RQ6
         end
      end
   end

   // An edge in the same cycle as the clearing read wins.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wgLatch <= 1'b0;
         rdLatch <= 1'b0;
         wdLatch <= 1'b0;
      end else begin
         if (wgRise) begin
            wgLatch <= 1'b1; // see RQ8
         end else if (dirRead) begin
            wgLatch <= 1'b0;
         end
         if (rdFall) begin
            rdLatch <= 1'b1; // see RQ9
         end else if (dirRead) begin
            rdLatch <= 1'b0;
         end
         if (wdFall) begin
            wdLatch <= 1'b1; // see RQ10
         end else if (dirRead) begin
            wdLatch <= 1'b0;
         end
      end
   end

   always_comb begin
      statusFull = 8'h00;
      statusFull[7:6] = 2'b11; // see RQ2
      statusFull[0] = driveOutputReg[fdcreg_pkg::BIT_MOTOR0]; // see RQ3
      statusFull[1] = 1'b0; // see RQ25
      statusFull[2] = wgSync[2]; // see RQ4
      statusFull[3] = readToggle; // see RQ5
      statusFull[4] = writeToggle; // see RQ6
      statusFull[5] = driveOutputReg[0]; // see RQ7
   end

   always_comb begin
      statusLatched = 8'h00;
      statusLatched[1:0] = 2'b11; // see RQ11
      statusLatched[2] = wgLatch; // see RQ8
      statusLatched[3] = rdLatch; // see RQ9
      statusLatched[4] = wdLatch; // see RQ10
      statusLatched[5] = driveSelect0N; // see RQ11
      statusLatched[6] = 1'b1; // see RQ11
      statusLatched[7] = 1'b1; // see RQ25
   end

   // Config pair chosen by drive number bits. (see RQ24)
   function automatic logic [1:0] typePair(input logic [7:0] cfg,
                                           input logic [1:0] drv);
      case (drv)
         2'h0: typePair = cfg[1:0];
         2'h1: typePair = cfg[3:2];
         2'h2: typePair = cfg[5:4];
         2'h3: typePair = cfg[7:6];
         default: typePair = 2'h0;
      endcase
   endfunction

   always_comb begin
      tapeRead = {6'h00, tapeDriveReg}; // see RQ22
      if (enhancedTape) begin
         tapeRead[5:4] = typePair(driveTypeCfg, driveOutputReg[1:0]); // see RQ23
      end
   end

   always_comb begin
      next_readData = 8'h00;
      case (regIdx)
         fdcreg_pkg::IDX_STATUS_B: begin
            if (statusMode == fdcreg_pkg::MODE_FULL) begin
               next_readData = statusFull;
            end else if (statusMode == fdcreg_pkg::MODE_LATCHED) begin
               next_readData = statusLatched;
            end
         end
         fdcreg_pkg::IDX_DRIVE_OUT: next_readData = driveOutputReg;
         fdcreg_pkg::IDX_TAPE: next_readData = tapeRead;
         fdcreg_pkg::IDX_MODE: next_readData = {3'h0, enhancedTape,
                                                2'h0, statusMode};
         default: next_readData = 8'h00;
      endcase
   end

   // Bus answer: ack for mapped, err for unmapped, one cycle after request.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         dataBusOe <= 1'b0;
      end else begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         dataBusOe <= 1'b0;
         if (request) begin
            case (regIdx)
               fdcreg_pkg::IDX_STATUS_B,
               fdcreg_pkg::IDX_DRIVE_OUT,
               fdcreg_pkg::IDX_TAPE,
               fdcreg_pkg::IDX_MODE,
               fdcreg_pkg::IDX_DIR_READ: begin
                  wb_ack_o <= 1'b1;
                  // Legacy status B reads leave the pins undriven. (see RQ1)
                  // An unmapped read gets err and never drives the pins.
                  dataBusOe <= !wb_we_i
                     && !(regIdx == fdcreg_pkg::IDX_STATUS_B
                     && statusMode == fdcreg_pkg::MODE_LEGACY);
               end
               default: wb_err_o <= 1'b1;
            endcase
         end
         if (readHit) begin
            wb_dat_o <= {24'h00_0000, next_readData};
         end
      end
   end

   // Binary drive number makes at most one select active. (see RQ13)
   assign driveEn0 = driveOutputReg[1:0] == 2'h0
      && driveOutputReg[fdcreg_pkg::BIT_MOTOR0];
   assign driveEn1 = driveOutputReg[1:0] == 2'h1
      && driveOutputReg[fdcreg_pkg::BIT_MOTOR1];
   assign dmaIrqEnable = statusMode == fdcreg_pkg::MODE_FULL
      || driveOutputReg[fdcreg_pkg::BIT_DMA_EN];

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         driveSelect0N <= 1'b1;
         driveSelect1N <= 1'b1;
         motorOn0N <= 1'b1;
         motorOn1N <= 1'b1;
         dmaReqOut <= 1'b0;
         irqOut <= 1'b0;
      end else begin
         if (swapDrives) begin
            driveSelect0N <= !driveEn1; // see RQ20
            driveSelect1N <= !driveEn0; // see RQ20
            motorOn0N <= !driveOutputReg[fdcreg_pkg::BIT_MOTOR1]; // see RQ20
            motorOn1N <= !driveOutputReg[fdcreg_pkg::BIT_MOTOR0];
         end else begin
            driveSelect0N <= !driveEn0; // see RQ19
            driveSelect1N <= !driveEn1; // see RQ19
            motorOn0N <= !driveOutputReg[fdcreg_pkg::BIT_MOTOR0]; // see RQ18
            motorOn1N <= !driveOutputReg[fdcreg_pkg::BIT_MOTOR1]; // see RQ18
         end
         // Full mode ignores the enable bit. (see RQ16) (see RQ17)
         dmaReqOut <= dmaReqIn && dmaIrqEnable;
         irqOut <= irqIn && dmaIrqEnable;
      end
   end
endmodule

/* tb/fdcreg_sva.sv */
// Purpose: Port-level checks of the floppy register group.
// Assumes: Drive output register at byte address 0xFC8.
// Notes: Pins follow a register write one cycle after ack.
module fdcreg_sva #(
   parameter int SOFT_RESET_HOLD = 4
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [fdcreg_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic dataBusOe,
   input wire logic swapDrives,
   input wire logic dmaReqIn,
   input wire logic driveSelect0N,
   input wire logic driveSelect1N,
   input wire logic motorOn0N,
   input wire logic motorOn1N,
   input wire logic dmaReqOut,
   input wire logic controllerResetN
);
   logic wrDrv;
   logic [7:0] lowCnt;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   assign wrDrv = wb_ack_o & wb_we_i & wb_sel_i[0] & (wb_adr_i == 14'h0fc8);
   // Saturates so a long low on controllerResetN cannot wrap to a small count.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lowCnt <= 8'h00;
      end else if (controllerResetN) begin
         lowCnt <= 8'h00;
      end else if (lowCnt != 8'hff) begin
         lowCnt <= lowCnt + 8'h01;
      end
   end
   ack_one_cycle_a: assert property (
      wb_cyc_i & wb_stb_i & !wb_ack_o & !wb_err_o |=> wb_ack_o ^ wb_err_o)
      else $error("request not answered once");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   oe_with_read_a: assert property (
      dataBusOe |-> wb_ack_o & !wb_we_i) else $error("bus driven off a read");
   one_select_a: assert property (
      driveSelect0N | driveSelect1N) else $error("two drives selected");
   normal_motor_a: assert property (wrDrv & !swapDrives |=>
      motorOn0N == !$past(wb_dat_i[4]) && motorOn1N == !$past(wb_dat_i[5]))
      else $error("motor pins wrong in normal decode");
   swap_motor_a: assert property (wrDrv & swapDrives |=>
      motorOn0N == !$past(wb_dat_i[5]) && motorOn1N == !$past(wb_dat_i[4]))
      else $error("motor pins wrong in swapped decode");
   select_decode_a: assert property (
      wrDrv & wb_dat_i[1:0] == 2'h0 & wb_dat_i[4] |=>
      (swapDrives ? !driveSelect1N : !driveSelect0N))
      else $error("drive zero not selected");
   soft_reset_a: assert property (wrDrv & !wb_dat_i[2] |=>
      !controllerResetN) else $error("core reset not asserted");
   reset_hold_a: assert property ($rose(controllerResetN) |->
      lowCnt >= SOFT_RESET_HOLD) else $error("core reset too short");
   dma_gate_a: assert property (dmaReqOut |-> $past(dmaReqIn))
      else $error("dma request without cause");
   cover property (wrDrv & swapDrives);
   cover property ($rose(controllerResetN));
   cover property (wb_err_o);
endmodule

bind fdcreg_top fdcreg_sva #(.SOFT_RESET_HOLD(SOFT_RESET_HOLD)) chk (.*);

/* tb/fdcreg_drive_model.sv */
// Purpose: Behavioural disk drive and write channel on the far side.
// Assumes: Lines are active high and change after a rising edge.
// Notes: Each level is held long enough to cross the synchroniser.
module fdcreg_drive_model (
   input wire logic clk,
   input wire logic driveSelect0N,
   input wire logic motorOn0N,
   output logic readDataIn,
   output logic writeGateIn,
   output logic writeDataIn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] raw = 3'h0;
   // A real drive only sends read data while selected and spinning.
   assign readDataIn = raw[0] & ~driveSelect0N & ~motorOn0N;
   assign writeGateIn = raw[1];
   assign writeDataIn = raw[2];
   task automatic setLine(input int b, input logic v);
      @(posedge clk);
      raw[b] <= v;
      repeat (6) @(posedge clk);
   endtask
   task automatic pulse(input int b);
      setLine(b, 1'b1);
      setLine(b, 1'b0);
   endtask
endmodule

/* tb/fdcreg_bench.sv */
// Purpose: Self-checking bench of the floppy register group.
// Assumes: Mode register bit 4 selects the enhanced tape view.
// Notes: Bench signals carry the port names so instances connect by name.
module fdcreg_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [13:0] SB = 14'h0fc4, DRV = 14'h0fc8, TAP = 14'h0fcc;
   localparam logic [13:0] MODE = 14'h1000, DIR = 14'h1004;
   logic clk = 1'b0, reset_n = 1'b0, swapDrives = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [13:0] wb_adr_i = 14'h0000;
   logic [3:0] wb_sel_i = 4'h1;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
   logic [7:0] driveTypeCfg = 8'he4, got;
   logic dmaReqIn = 1'b0, irqIn = 1'b0, gotOe, gotErr;
   logic wb_ack_o, wb_err_o, dataBusOe, readDataIn, writeGateIn, writeDataIn;
   logic driveSelect0N, driveSelect1N, motorOn0N, motorOn1N;
   logic dmaReqOut, irqOut, controllerResetN;
   int failures = 0, samples_checked = 0, cycles = 0;
   fdcreg_top dut (.*);
   fdcreg_drive_model drv (.*);
   always #12.5 clk = ~clk;
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         tally_and_finish;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic [13:0] a, input logic w, input logic [7:0] d);
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= {24'h00_0000, d};
      do @(posedge clk); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
      got = wb_dat_o[7:0];
      gotOe = dataBusOe;
      gotErr = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task automatic wr(input logic [13:0] a, input logic [7:0] d);
      bus(a, 1'b1, d);
      repeat (2) @(posedge clk);
   endtask
   task automatic rdChk(input logic [13:0] a, input logic [7:0] e);
      bus(a, 1'b0, 8'h00);
      chk(got, e);
   endtask
   function automatic logic [3:0] pins();
      return {driveSelect1N, driveSelect0N, motorOn1N, motorOn0N};
   endfunction
   initial begin
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      rdChk(DRV, 8'h00);
      chk(controllerResetN, 1'b0);
      bus(SB, 1'b0, 8'h00);
      chk(gotOe, 1'b0);
      dmaReqIn <= 1'b1;
      irqIn <= 1'b1;
      wr(DRV, 8'h14);
      chk({dmaReqOut, irqOut}, 2'h0);
      wr(DRV, 8'h1c);
      chk({dmaReqOut, irqOut}, 2'h3);
      chk(pins(), 4'ha);
      wr(MODE, 8'h01);
      wr(DRV, 8'h14);
      chk({dmaReqOut, irqOut}, 2'h3);
      rdChk(SB, 8'hc1);
      chk(gotOe, 1'b1);
      wr(DRV, 8'h2d);
      chk(pins(), 4'h5);
      rdChk(SB, 8'he0);
      swapDrives <= 1'b1;
      wr(DRV, 8'h1c);
      chk(pins(), 4'h5);
      swapDrives <= 1'b0;
      wr(DRV, 8'h1c);
      drv.setLine(1, 1'b1);
      rdChk(SB, 8'hc5);
      drv.setLine(1, 1'b0);
      drv.pulse(0);
      rdChk(SB, 8'hc9);
      drv.pulse(2);
      rdChk(SB, 8'hd9);
      drv.pulse(0);
      rdChk(SB, 8'hd1);
      wr(DRV, 8'h18);
      chk(controllerResetN, 1'b0);
      wr(DRV, 8'h1c);
      chk(pins(), 4'ha);
      rdChk(DRV, 8'h1c);
      wb_sel_i <= 4'h0;
      wr(DRV, 8'h00);
      wb_sel_i <= 4'h1;
      rdChk(DRV, 8'h1c);
      rdChk(SB, 8'hd1);
      for (int n = 0; n < 20 && controllerResetN !== 1'b1; n++) @(posedge clk);
      chk(controllerResetN, 1'b1);
      wr(MODE, 8'h02);
      bus(DIR, 1'b0, 8'h00);
      rdChk(SB, 8'hc3);
      drv.pulse(1);
      rdChk(SB, 8'hc7);
      drv.pulse(2);
      rdChk(SB, 8'hd7);
      bus(DIR, 1'b0, 8'h00);
      rdChk(SB, 8'hc3);
      drv.pulse(0);
      wr(DRV, 8'h0c);
      rdChk(SB, 8'heb);
      wr(MODE, 8'h01);
      wr(TAP, 8'hff);
      rdChk(TAP, 8'h03);
      wr(MODE, 8'h11);
      for (int k = 0; k < 4; k++) begin
         wr(DRV, 8'h0c | 8'(k));
         rdChk(TAP, {2'h0, driveTypeCfg[2 * k +: 2], 4'h3});
      end
      bus(14'h0fd0, 1'b0, 8'h00);
      chk(gotErr, 1'b1);
      reset_n <= 1'b0;
      @(posedge clk);
      reset_n <= 1'b1;
      rdChk(DRV, 8'h00);
      tally_and_finish;
   end
endmodule
